/* File: bus_cycle_seq.v */
// Purpose: Runs one primary bus access of one cycle plus wait states.
// Assumes: Start is taken only while idle; inputs synchronous to clk.
// Notes: last_q marks the final cycle, the point where hold is sampled.
`include "bus_hold_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module bus_cycle_seq (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	input wire ce,
	// Control
	input wire start,
	input wire [`WAIT_W-1:0] wait_count,
	// Status
	output reg busy_q,
	output reg last_q,
	output reg done_q
);

	reg [1:0] st_q;
	reg [`WAIT_W-1:0] cnt_q;

	// ==========================================================
	// Sequencer
	always @(posedge clk) begin
		if (!rst_n) begin
			st_q <= `BC_IDLE;
			cnt_q <= `WAIT_RST;
			busy_q <= 1'b0;
			last_q <= 1'b0;
			done_q <= 1'b0;
		end else if (ce) begin
			done_q <= 1'b0;
			case (st_q)
				`BC_IDLE: begin
					if (start) begin
						busy_q <= 1'b1;
						cnt_q <= wait_count;
						st_q <= (wait_count == `WAIT_RST) ? `BC_LAST : `BC_WAIT;
						last_q <= (wait_count == `WAIT_RST);
					end
				end
				`BC_WAIT: begin
					cnt_q <= cnt_q - 1'b1;
					if (cnt_q == 3'h1) begin
						st_q <= `BC_LAST;
						last_q <= 1'b1;
					end
				end
				`BC_LAST: begin
					st_q <= `BC_IDLE;
					busy_q <= 1'b0;
					last_q <= 1'b0;
					done_q <= 1'b1;
				end
				default: begin
					st_q <= `BC_IDLE;
					busy_q <= 1'b0;
					last_q <= 1'b0;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

/* File: bus_hold_defs.vh */
// Purpose: Constants for the primary bus hold handshake block.
// Assumes: One clock at 10 MHz; one clock edge stands for one core_clock_phase cycle.
// Notes: Wait-state count is a field width; the extra hold width term is a count.
`ifndef BUS_HOLD_DEFS_VH
`define BUS_HOLD_DEFS_VH

// ==========================================================
// Widths
`define ADDR_W 24
`define DATA_W 32
`define WAIT_W 3

// ==========================================================
// Hold state codes
`define ST_RUN 2'h0
`define ST_DRAIN 2'h1
`define ST_HOLD 2'h2
`define ST_LEAVE 2'h3

// ==========================================================
// Bus cycle sequencer codes
`define BC_IDLE 2'h0
`define BC_WAIT 2'h1
`define BC_LAST 2'h2

// ==========================================================
// Reset values
`define WAIT_RST 3'h0

`endif

/* File: hold_master.sv */
// Purpose: Outside master model that asks for the bus
// Assumes: go comes from the bench; wt mirrors wait states
// Notes: Holds its request past grant and minimum width
`timescale 1ns/1ps
`default_nettype none
// ====
module hold_master (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic go,
	input wire logic [2:0] wt,
	input wire logic g_n,
	// Pin
	output logic req_n = 1'b1
);
	logic [3:0] n_q;
	logic seen_q;
	// Ask, then release once long enough and granted
	always @(posedge clk) begin
		if (!rst_n || req_n) begin
			req_n <= !(rst_n && go);
			n_q <= 4'h0;
			seen_q <= 1'b0;
		end else begin
			n_q <= n_q + 4'h1;
			seen_q <= seen_q | !g_n;
			if (seen_q && !go && n_q >= {1'b0, wt} + 4'h3) begin
				req_n <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: primary_bus_hold_handshake.v */
// Purpose: Hands the primary bus to an outside master by hold request and grant.
// Assumes: hold_req_n synchronous to clk; core requests held until accepted.
// Notes: Output enables are high while this block drives the pin.
// Function
// - The hold request is a synchronous input that may change anywhere in a cycle.
// - A request that misses the sampling point is served one cycle later.
// - While the hold disable bit is set requests are ignored and a running hold ends.
// - During hold no bus access is made and the core stalls at the first bus access it cannot park.
// - One write may be parked during hold; a read or a second write stalls the core.
// - The request is captured one cycle before the current bus cycle ends.
// - The grant goes low for the request and rises three cycles after the request rises.
// - The strobe is driven high before the bus is floated.
// - Strobe, direction, address and data float in hold; control and address return after.
`include "bus_hold_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module primary_bus_hold_handshake (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	input wire ce,
	// Configuration
	input wire hold_disable_bit,
	input wire [`WAIT_W-1:0] wait_state_count,
	// Outside master
	input wire hold_req_n,
	output reg bus_hold_grant_n_q,
	// Core access request
	input wire core_req,
	input wire core_wr,
	input wire [`ADDR_W-1:0] core_addr,
	input wire [`DATA_W-1:0] core_wdata,
	output reg core_stall_q,
	output reg core_done_q,
	// Primary bus pins
	output reg bus_access_strobe_n_q,
	output reg bus_access_strobe_oe_q,
	output reg bus_rw_q,
	output reg bus_rw_oe_q,
	output reg [`ADDR_W-1:0] bus_addr_q,
	output reg bus_addr_oe_q,
	output reg [`DATA_W-1:0] bus_data_q,
	output reg bus_data_oe_q
);

	reg [1:0] hst_q;
	reg req_q;
	reg park_q;
	reg park_wr_q;
	reg [`ADDR_W-1:0] park_addr_q;
	reg [`DATA_W-1:0] park_data_q;
	reg start;
	reg start_wr;
	reg [`ADDR_W-1:0] start_addr;
	reg [`DATA_W-1:0] start_data;
	reg from_park;
	wire busy;
	wire last;
	wire want;
	wire idle_ok;

	// Sequencer for one bus cycle with wait states
	bus_cycle_seq u_seq (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.start(start),
		.wait_count(wait_state_count),
		.busy_q(busy),
		.last_q(last),
		.done_q()
	);

	// ==========================================================
	// Request capture
	// Sampled request, ignored while disabled
	assign want = req_q & ~hold_disable_bit;
	// Bus may be given only between cycles
	assign idle_ok = ~busy | last;

	always @(posedge clk) begin
		if (!rst_n) begin
			req_q <= 1'b0;
		end else if (ce) begin
			req_q <= ~hold_req_n;
		end
	end

	// ==========================================================
	// Start selection: parked write first, then core access
	always @* begin
		start = 1'b0;
		start_wr = 1'b0;
		start_addr = core_addr;
		start_data = core_wdata;
		from_park = 1'b0;
		if (hst_q == `ST_RUN && !busy && !want) begin
			if (park_q) begin
				start = 1'b1;
				start_wr = park_wr_q;
				start_addr = park_addr_q;
				start_data = park_data_q;
				from_park = 1'b1;
			end else if (core_req) begin
				start = 1'b1;
				start_wr = core_wr;
			end
		end
	end

	// ==========================================================
	// Hold state machine and bus pins
	always @(posedge clk) begin
		if (!rst_n) begin
			hst_q <= `ST_RUN;
			bus_hold_grant_n_q <= 1'b1;
			park_q <= 1'b0;
			park_wr_q <= 1'b0;
			park_addr_q <= 24'h00_0000;
			park_data_q <= 32'h0000_0000;
			core_stall_q <= 1'b0;
			core_done_q <= 1'b0;
			bus_access_strobe_n_q <= 1'b1;
			bus_access_strobe_oe_q <= 1'b1;
			bus_rw_q <= 1'b1;
			bus_rw_oe_q <= 1'b1;
			bus_addr_q <= 24'h00_0000;
			bus_addr_oe_q <= 1'b1;
			bus_data_q <= 32'h0000_0000;
			bus_data_oe_q <= 1'b0;
		end else if (ce) begin
			core_done_q <= 1'b0;
			core_stall_q <= 1'b0;
			// Launch a bus access
			if (start) begin
				bus_access_strobe_n_q <= 1'b0;
				bus_rw_q <= ~start_wr;
				bus_addr_q <= start_addr;
				bus_data_q <= start_data;
				bus_data_oe_q <= start_wr;
				if (from_park) begin
					park_q <= 1'b0;
				end else begin
					core_done_q <= 1'b1;
				end
			end
			// End of a bus access at its last cycle, so the next one sees an idle gap
			if (last) begin
				bus_access_strobe_n_q <= 1'b1;
				bus_data_oe_q <= 1'b0;
			end
			case (hst_q)
				`ST_RUN: begin
					// Request seen at the last cycle or idle; late ones wait a cycle
					if (want && idle_ok) begin
						hst_q <= `ST_DRAIN;
					end
				end
				`ST_DRAIN: begin
					// Strobe goes inactive before floating
					bus_access_strobe_n_q <= 1'b1;
					if (!want) begin
						hst_q <= `ST_RUN;
					end else if (!busy) begin
						hst_q <= `ST_HOLD;
						bus_hold_grant_n_q <= 1'b0;
						bus_access_strobe_oe_q <= 1'b0;
						bus_rw_oe_q <= 1'b0;
						bus_addr_oe_q <= 1'b0;
						bus_data_oe_q <= 1'b0;
					end
				end
				`ST_HOLD: begin
					// Core runs on; first write parks, further accesses stall
					if (core_req) begin
						if (core_wr && !park_q) begin
							park_q <= 1'b1;
							park_wr_q <= 1'b1;
							park_addr_q <= core_addr;
							park_data_q <= core_wdata;
							core_done_q <= 1'b1;
						end else begin
							core_stall_q <= 1'b1;
						end
					end
					// Grant held one cycle past request release, or dropped on disable
					if (!want) begin
						hst_q <= `ST_LEAVE;
					end
				end
				`ST_LEAVE: begin
					hst_q <= `ST_RUN;
					bus_hold_grant_n_q <= 1'b1;
					bus_access_strobe_oe_q <= 1'b1;
					bus_rw_oe_q <= 1'b1;
					bus_addr_oe_q <= 1'b1;
					core_stall_q <= core_req & ~(core_wr & ~park_q);
				end
				default: begin
					hst_q <= `ST_RUN;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

/* File: primary_bus_hold_handshake_assertions.sv */
// Purpose: Checks the hold handshake at the block ports
// Assumes: ce held high
// Notes: Bound to the block after the module
`timescale 1ns/1ps
`default_nettype none
// ====
module bus_hold_checks (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Handshake
	input wire logic hold_disable_bit,
	input wire logic hold_req_n,
	input wire logic bus_hold_grant_n_q,
	input wire logic core_stall_q,
	// Bus pins
	input wire logic bus_access_strobe_n_q,
	input wire logic bus_access_strobe_oe_q,
	input wire logic bus_rw_oe_q,
	input wire logic bus_addr_oe_q,
	input wire logic bus_data_oe_q
);
	// Short aliases
	wire g = bus_hold_grant_n_q;
	wire dis = hold_disable_bit;
	wire ctl = bus_access_strobe_oe_q & bus_rw_oe_q & bus_addr_oe_q;
	wire any = ctl | bus_access_strobe_oe_q | bus_rw_oe_q | bus_addr_oe_q | bus_data_oe_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_float; !g |-> !any; endproperty
	property p_back; $rose(g) |-> ctl && !bus_data_oe_q; endproperty
	property p_bus_access_strobe; $fell(g) |-> $past(bus_access_strobe_n_q); endproperty
	property p_cause; $fell(g) |-> !$past(hold_req_n, 2); endproperty
	property p_exit; $rose(hold_req_n) && !g && !dis |-> ##1 !g ##1 !g ##1 g; endproperty
	property p_dis; dis && !g |-> ##[1:3] g; endproperty
	property p_refuse; dis && $past(dis) && $past(dis, 2) |-> g; endproperty
	property p_prompt; $fell(hold_req_n) && !dis |-> ##[1:16] (!g || dis); endproperty
	a_float: assert property (p_float) else $error("bus driven in hold");
	a_back: assert property (p_back) else $error("bus not restored");
	a_bus_access_strobe: assert property (p_bus_access_strobe) else $error("strobe low at grant");
	a_cause: assert property (p_cause) else $error("grant without request");
	a_exit: assert property (p_exit) else $error("grant exit timing");
	a_dis: assert property (p_dis) else $error("hold kept when disabled");
	a_refuse: assert property (p_refuse) else $error("grant while disabled");
	a_prompt: assert property (p_prompt) else $error("grant too late");
	c_hold: cover property ($fell(g));
	c_dis: cover property (dis && !g);
	c_stall: cover property (core_stall_q);
endmodule
bind primary_bus_hold_handshake bus_hold_checks bus_hold_checks_i (.clk, .rst_n,
	.hold_disable_bit, .hold_req_n, .bus_hold_grant_n_q, .core_stall_q, .bus_access_strobe_n_q,
	.bus_access_strobe_oe_q, .bus_rw_oe_q, .bus_addr_oe_q, .bus_data_oe_q);
`default_nettype wire

/* File: tb_primary_bus_hold_handshake.sv */
// Purpose: Self-checking bench for the hold handshake
// Assumes: ce tied high; xorshift seed 4
// Notes: Strobe run length is watched a step after each edge
`include "bus_hold_defs.vh"
`timescale 1ns/1ps
`default_nettype none
// ====
module tb_primary_bus_hold_handshake;
	logic clk = 0, rst_n = 0, ce = 1, dis = 0, go = 0, req = 0, wr = 0;
	logic [2:0] wt = 3'h0;
	logic [`ADDR_W-1:0] adr = 24'h00_0000;
	logic [`DATA_W-1:0] wd = 32'h0000_0000, rs = 32'h0000_0004;
	wire g_n, rq_n, st_n, st_oe, rw, rw_oe, a_oe, d_oe, stall, done;
	wire [`ADDR_W-1:0] ba;
	wire [`DATA_W-1:0] bd;
	int miscompares = 0, compares = 0, run = 0, last = 0, k;
	primary_bus_hold_handshake primary_bus_hold_handshake_i (.clk(clk), .rst_n(rst_n),
		.ce(ce), .hold_disable_bit(dis), .wait_state_count(wt), .hold_req_n(rq_n),
		.bus_hold_grant_n_q(g_n), .core_req(req), .core_wr(wr), .core_addr(adr),
		.core_wdata(wd), .core_stall_q(stall), .core_done_q(done),
		.bus_access_strobe_n_q(st_n), .bus_access_strobe_oe_q(st_oe), .bus_rw_q(rw),
		.bus_rw_oe_q(rw_oe), .bus_addr_q(ba), .bus_addr_oe_q(a_oe), .bus_data_q(bd),
		.bus_data_oe_q(d_oe));
	hold_master hold_master_i (.clk(clk), .rst_n(rst_n), .go(go), .wt(wt), .g_n(g_n),
		.req_n(rq_n));
	// Clock and strobe run monitor
	initial forever #50 clk = ~clk;
	always begin
		@(posedge clk);
		#1;
		if (st_n === 1'b0) run++;
		else if (run > 0) begin
			last = run;
			run = 0;
		end
	end
	function logic [31:0] xs(input logic [31:0] s);
		xs = s ^ (s << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	function int len_exp(input logic [2:0] w);
		len_exp = w + 1;
	endfunction
	task report_and_stop;
		if (miscompares == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wg(input logic v);
		for (k = 0; k < 40 && g_n !== v; k++) cyc(1);
		chk("grant", v, g_n);
	endtask
	task start(input logic w);
		@(posedge clk);
		req <= 1;
		wr <= w;
		adr <= rs[23:0];
		wd <= rs;
		rs = xs(rs);
	endtask
	task fin;
		for (k = 0; k < 40 && done !== 1'b1; k++) cyc(1);
		chk("done", 1, done);
		req <= 0;
	endtask
	// Watchdog
	initial begin
		#(3000 * 100);
		miscompares++;
		report_and_stop;
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		go <= 1;
		wg(0);
		chk("oe", 0, {st_oe, rw_oe, a_oe, d_oe});
		chk("strobe", 1, st_n);
		go <= 0;
		wg(1);
		chk("oe", 4'he, {st_oe, rw_oe, a_oe, d_oe});
		for (int i = 0; i < 8; i++) begin
			wt <= i[2:0];
			start(rs[0]);
			fin;
			chk("addr", adr, ba);
			chk("rw", !wr, rw);
			chk("data_oe", wr, d_oe);
			if (wr) chk("data", wd, bd);
			go <= 1;
			wg(0);
			chk("len", len_exp(i[2:0]), last);
			go <= 0;
			wg(1);
		end
		go <= 1;
		wg(0);
		start(1);
		fin;
		start(1);
		cyc(4);
		chk("stall", 1, stall);
		chk("quiet", 0, {st_oe, done});
		go <= 0;
		fin;
		go <= 1;
		wg(0);
		dis <= 1;
		wg(1);
		go <= 0;
		cyc(12);
		go <= 1;
		cyc(12);
		chk("refuse", 1, g_n);
		dis <= 0;
		wg(0);
		go <= 0;
		wg(1);
		report_and_stop;
	end
endmodule
`default_nettype wire
